// ==== design/arp_match_pkg.sv ====
/*
  arp_match_pkg: register map, field layouts, reset values and carrier
  types for the arp/rarp access control entry matcher.
  assumes: a 32-bit axi4-lite register bus and a parsed-frame source.
*/
package arp_match_pkg;

  // register byte offsets
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_sender_addr = 8'h04;
  localparam logic [7:0] off_sender_mask = 8'h08;
  localparam logic [7:0] off_target_addr = 8'h0c;
  localparam logic [7:0] off_target_mask = 8'h10;
  localparam logic [7:0] off_status = 8'h14;
  localparam logic [7:0] off_hit_count = 8'h18;

  // control field positions
  localparam int ctrl_sender_mode_lsb = 0;
  localparam int ctrl_target_mode_lsb = 2;
  localparam int ctrl_sha_lsb = 4;
  localparam int ctrl_tha_lsb = 6;
  localparam int ctrl_len_lsb = 8;
  localparam int ctrl_hrd_lsb = 10;
  localparam int ctrl_pro_lsb = 12;
  localparam int ctrl_enable_bit = 14;
  localparam logic [31:0] ctrl_write_mask = 32'h0000_7fff;

  // reset values: entry off, every criterion any
  localparam logic [31:0] ctrl_reset = 32'h0000_3fff;
  localparam logic [31:0] addr_reset = 32'h0000_0000;
  localparam logic [31:0] mask_reset = 32'hffff_ffff;

  // protocol constants used by the qualifiers
  localparam logic [7:0] hw_len_ethernet = 8'h06;
  localparam logic [7:0] proto_len_ipv4 = 8'h04;
  localparam logic [15:0] hw_type_ethernet = 16'h0001;
  localparam logic [15:0] proto_type_ip = 16'h0800;

  localparam logic [1:0] axi_okay = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;

  // protocol address criterion encoding
  typedef enum logic [1:0] {
    addr_host = 2'h0,
    addr_network = 2'h1,
    addr_any = 2'h3
  } addr_mode_e;

  // three-way qualifier encoding
  typedef enum logic [1:0] {
    qual_false = 2'h0,
    qual_true = 2'h1,
    qual_any = 2'h3
  } qual_mode_e;

  typedef enum logic [1:0] {
    op_arp,
    op_rarp,
    op_other
  } arp_kind_e;

  typedef struct packed {
    arp_kind_e kind;
    logic [47:0] frame_source_mac;
    logic [15:0] hw_type;
    logic [15:0] proto_type;
    logic [7:0] hw_len;
    logic [7:0] proto_len;
    logic [47:0] sender_hw_addr;
    logic [31:0] sender_proto_addr;
    logic [47:0] target_hw_addr;
    logic [31:0] target_proto_addr;
  } arp_frame_s;

  typedef struct packed {
    addr_mode_e sender_mode;
    addr_mode_e target_mode;
    qual_mode_e sha_mode;
    qual_mode_e tha_mode;
    qual_mode_e len_mode;
    qual_mode_e hrd_mode;
    qual_mode_e pro_mode;
    logic [31:0] sender_addr;
    logic [31:0] sender_mask;
    logic [31:0] target_addr;
    logic [31:0] target_mask;
  } entry_cfg_s;

endpackage

// ==== design/entry_compare.sv ====
/*
  entry_compare: combinational decision of one access control entry
  against one parsed arp/rarp frame.
  assumes: frame fields already extracted; result registered by caller.
*/
`timescale 1ns/1ps
module entry_compare (
  input wire arp_match_pkg::arp_frame_s frame,
  input wire arp_match_pkg::entry_cfg_s cfg,
  output logic hit
);
  import arp_match_pkg::*;

  function automatic logic addr_pass(input addr_mode_e mode,
                                     input logic [31:0] frame_addr,
                                     input logic [31:0] cfg_addr,
                                     input logic [31:0] cfg_mask);
    case (mode)
      addr_host: addr_pass = (frame_addr == cfg_addr);
      // only bits selected by the mask are compared
      addr_network: addr_pass =
        ((frame_addr ^ cfg_addr) & cfg_mask) == 32'h0000_0000;
      default: addr_pass = 1'b1;
    endcase
  endfunction

  // 0 wants the condition false, 1 true, any ignores it
  function automatic logic qual_pass(input qual_mode_e mode,
                                     input logic cond);
    case (mode)
      qual_false: qual_pass = !cond;
      qual_true: qual_pass = cond;
      default: qual_pass = 1'b1;
    endcase
  endfunction

  logic sender_ok;
  logic target_ok;
  logic sha_ok;
  logic tha_ok;
  logic len_ok;
  logic hrd_ok;
  logic pro_ok;

  always_comb begin
    sender_ok = addr_pass(cfg.sender_mode, frame.sender_proto_addr,
                          cfg.sender_addr, cfg.sender_mask);
    target_ok = addr_pass(cfg.target_mode, frame.target_proto_addr,
                          cfg.target_addr, cfg.target_mask);
    // sha qualifier restricts to arp frames unless set to any
    // code 2 acts as any, so only 0 and 1 restrict the frame kind
    sha_ok = ((cfg.sha_mode != qual_false) &&
              (cfg.sha_mode != qual_true)) ||
             ((frame.kind == op_arp) &&
              qual_pass(cfg.sha_mode,
                frame.sender_hw_addr == frame.frame_source_mac));
    tha_ok = ((cfg.tha_mode != qual_false) &&
              (cfg.tha_mode != qual_true)) ||
             ((frame.kind == op_rarp) &&
              qual_pass(cfg.tha_mode,
                frame.target_hw_addr == frame.frame_source_mac));
    len_ok = qual_pass(cfg.len_mode,
                       (frame.hw_len == hw_len_ethernet) &&
                       (frame.proto_len == proto_len_ipv4));
    hrd_ok = qual_pass(cfg.hrd_mode,
                       frame.hw_type == hw_type_ethernet);
    pro_ok = qual_pass(cfg.pro_mode,
                       frame.proto_type == proto_type_ip);
    hit = sender_ok && target_ok && sha_ok && tha_ok &&
          len_ok && hrd_ok && pro_ok;
  end

endmodule

// ==== design/arp_ace_field_matcher.sv ====
/*
  arp_ace_field_matcher: arp/rarp criteria of one access control entry,
  set over axi4-lite, judging each frame from the ingress parser.
  assumes: parser gives one frame per frame_valid cycle; single clock.
*/
`timescale 1ns/1ps
module arp_ace_field_matcher #(
  parameter int count_width = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_valid,
  input wire arp_match_pkg::arp_frame_s frame,
  output logic result_valid,
  output logic entry_hit
);
  import arp_match_pkg::*;

  initial begin
    if (count_width < 1 || count_width > 32) begin
      $error("count_width must be 1 to 32");
    end
  end

  // register state
  logic [31:0] ctrl;
  logic [31:0] sender_addr;
  logic [31:0] sender_mask;
  logic [31:0] target_addr;
  logic [31:0] target_mask;
  logic [count_width-1:0] hit_count;
  logic [count_width-1:0] frame_count;
  logic last_hit;
  logic [31:0] next_ctrl;
  logic [31:0] next_sender_addr;
  logic [31:0] next_sender_mask;
  logic [31:0] next_target_addr;
  logic [31:0] next_target_mask;
  logic [count_width-1:0] next_hit_count;
  logic [count_width-1:0] next_frame_count;
  logic next_last_hit;

  // write channel state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;

  // read channel state
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // match pipeline state
  logic res_valid;
  logic res_hit;
  logic next_res_valid;
  logic next_res_hit;

  entry_cfg_s cfg;
  logic comb_hit;
  logic do_write;
  logic clear_counts;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic [31:0] widen(input logic [count_width-1:0] v);
    widen = 32'h0000_0000;
    widen[count_width-1:0] = v;
  endfunction

  always_comb begin
    cfg.sender_mode = addr_mode_e'(ctrl[ctrl_sender_mode_lsb +: 2]);
    cfg.target_mode = addr_mode_e'(ctrl[ctrl_target_mode_lsb +: 2]);
    cfg.sha_mode = qual_mode_e'(ctrl[ctrl_sha_lsb +: 2]);
    cfg.tha_mode = qual_mode_e'(ctrl[ctrl_tha_lsb +: 2]);
    cfg.len_mode = qual_mode_e'(ctrl[ctrl_len_lsb +: 2]);
    cfg.hrd_mode = qual_mode_e'(ctrl[ctrl_hrd_lsb +: 2]);
    cfg.pro_mode = qual_mode_e'(ctrl[ctrl_pro_lsb +: 2]);
    cfg.sender_addr = sender_addr;
    cfg.sender_mask = sender_mask;
    cfg.target_addr = target_addr;
    cfg.target_mask = target_mask;
  end

  entry_compare entry_compare_inst (
    .frame(frame),
    .cfg(cfg),
    .hit(comb_hit)
  );

  // axi4-lite write: address and data accepted in either order
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    do_write = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (aw_held && w_held) begin
      do_write = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      case ({aw_addr[7:2], 2'b00})
        off_ctrl, off_sender_addr, off_sender_mask,
        off_target_addr, off_target_mask, off_status,
        off_hit_count: next_bresp = axi_okay;
        default: next_bresp = axi_slverr;
      endcase
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= axi_okay;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  // register file; writing the hit count register clears both counters
  always_comb begin
    next_ctrl = ctrl;
    next_sender_addr = sender_addr;
    next_sender_mask = sender_mask;
    next_target_addr = target_addr;
    next_target_mask = target_mask;
    clear_counts = 1'b0;
    if (do_write) begin
      case ({aw_addr[7:2], 2'b00})
        off_ctrl:
          next_ctrl = merge(ctrl, w_data, w_strb) & ctrl_write_mask;
        off_sender_addr:
          next_sender_addr = merge(sender_addr, w_data, w_strb);
        off_sender_mask:
          next_sender_mask = merge(sender_mask, w_data, w_strb);
        off_target_addr:
          next_target_addr = merge(target_addr, w_data, w_strb);
        off_target_mask:
          next_target_mask = merge(target_mask, w_data, w_strb);
        off_hit_count: clear_counts = 1'b1;
        default: clear_counts = 1'b0;
      endcase
    end
  end

  // frame judged one cycle after it is offered; disabled entry never hits
  always_comb begin
    next_res_valid = frame_valid;
    next_res_hit = frame_valid && ctrl[ctrl_enable_bit] && comb_hit;
    next_hit_count = hit_count;
    next_frame_count = frame_count;
    next_last_hit = last_hit;
    if (res_valid) begin
      next_frame_count = frame_count + 1'b1;
      next_last_hit = res_hit;
      if (res_hit) begin
        next_hit_count = hit_count + 1'b1;
      end
    end
    // counting wins over clear would lose the clear; clear takes priority
    if (clear_counts) begin
      next_hit_count = '0;
      next_frame_count = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= ctrl_reset;
      sender_addr <= addr_reset;
      sender_mask <= mask_reset;
      target_addr <= addr_reset;
      target_mask <= mask_reset;
      hit_count <= '0;
      frame_count <= '0;
      last_hit <= 1'b0;
      res_valid <= 1'b0;
      res_hit <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      sender_addr <= next_sender_addr;
      sender_mask <= next_sender_mask;
      target_addr <= next_target_addr;
      target_mask <= next_target_mask;
      hit_count <= next_hit_count;
      frame_count <= next_frame_count;
      last_hit <= next_last_hit;
      res_valid <= next_res_valid;
      res_hit <= next_res_hit;
    end
  end

  assign result_valid = res_valid;
  assign entry_hit = res_hit;

  // axi4-lite read: one outstanding, answer one cycle after address
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = axi_okay;
      case ({s_axi_araddr[7:2], 2'b00})
        off_ctrl: next_rdata = ctrl;
        off_sender_addr: next_rdata = sender_addr;
        off_sender_mask: next_rdata = sender_mask;
        off_target_addr: next_rdata = target_addr;
        off_target_mask: next_rdata = target_mask;
        off_status: next_rdata = {31'h0000_0000, last_hit};
        off_hit_count: next_rdata = widen(hit_count);
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = axi_slverr;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= axi_okay;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

endmodule

// ==== verification/arp_match_assertions.sv ====
/*
  arp_match_checker: port timing checks for the arp/rarp entry matcher.
  assumes: bound onto arp_ace_field_matcher; one clock, sync reset.
*/
`timescale 1ns/1ps
module arp_match_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_valid,
  input wire logic result_valid,
  input wire logic entry_hit
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_judged;
    ##1 result_valid;
  endsequence
  property p_result_follows; frame_valid |-> s_judged; endproperty
  property p_no_stray; result_valid |-> $past(frame_valid); endproperty
  property p_hit_qualified; entry_hit |-> result_valid; endproperty
  property p_write_answer; s_wr_taken |-> ##[1:3] s_axi_bvalid; endproperty
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_rvalid_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  property p_write_blocked;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_read_blocked; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_result_follows: assert property (p_result_follows)
    else $error("no result after frame");
  a_no_stray: assert property (p_no_stray)
    else $error("result without frame");
  a_hit_qualified: assert property (p_hit_qualified)
    else $error("hit outside result");
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");
  a_read_answer: assert property (p_read_answer)
    else $error("read response late");
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("bvalid dropped early");
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("rvalid dropped early");
  a_write_blocked: assert property (p_write_blocked)
    else $error("write accepted while answering");
  a_read_blocked: assert property (p_read_blocked)
    else $error("read accepted while answering");
endmodule

bind arp_ace_field_matcher arp_match_checker checker_inst (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .frame_valid(frame_valid), .result_valid(result_valid),
  .entry_hit(entry_hit)
);

// ==== verification/parser_model.sv ====
/*
  parser_model: stands in for the ingress parser, one frame per call.
  assumes: the bench calls send and idle, each after a clock edge.
*/
`timescale 1ns/1ps
module parser_model (
  input wire logic aclk,
  output logic frame_valid,
  output arp_match_pkg::arp_frame_s frame
);
  import arp_match_pkg::*;
  logic [287:0] w;
  initial begin
    frame_valid = 1'b0;
    frame = '0;
  end
  task automatic send(input arp_frame_s f);
    @(posedge aclk);
    frame_valid <= 1'b1;
    frame <= f;
  endtask
  // fields churn between frames so stale data never looks valid
  task automatic idle();
    @(posedge aclk);
    repeat (9) w = {w[255:0], $urandom};
    frame_valid <= 1'b0;
    frame <= arp_frame_s'(w[257:0]);
  endtask
endmodule

// ==== verification/test_arp_ace_field_matcher.sv ====
/*
  test_arp_ace_field_matcher: random entry settings over axi4-lite,
  random frames, results checked against a bench-side decision.
  assumes: the design package, parser_model and the bound checker.
*/
`timescale 1ns/1ps
module test_arp_ace_field_matcher;
  import arp_match_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, frame_valid;
  logic result_valid, entry_hit, en, e, last;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, hits, seed;
  logic [1:0] bresp, rresp;
  arp_frame_s frame, f;
  entry_cfg_s c;
  logic q[$];
  int fails, compares, cycles, k, j;
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, hits, fails, compares, cycles} = '0;
  end
  always #50 aclk = ~aclk;
  arp_ace_field_matcher arp_ace_field_matcher_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .frame_valid(frame_valid), .frame(frame),
    .result_valid(result_valid), .entry_hit(entry_hit));
  parser_model parser_model_inst (
    .aclk(aclk), .frame_valid(frame_valid), .frame(frame));
  task automatic close_out();
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    check(bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    check(rdata, d);
    check(rresp, r);
  endtask
  function automatic logic q3(qual_mode_e m, logic kind_ok, logic cond);
    if (m == qual_false) return kind_ok && !cond;
    if (m == qual_true) return kind_ok && cond;
    return 1'b1;
  endfunction
  function automatic logic am(addr_mode_e m, logic [31:0] fa, a, k);
    if (m == addr_host) return fa == a;
    if (m == addr_network) return ((fa ^ a) & k) == 0;
    return 1'b1;
  endfunction
  function automatic logic [31:0] near(logic [31:0] a, m, r);
    case ($urandom_range(0, 2))
      0: return a;
      1: return a ^ (r & ~m);
      default: return r;
    endcase
  endfunction
  function automatic logic ref_hit(arp_frame_s f);
    return en
      && am(c.sender_mode, f.sender_proto_addr, c.sender_addr,
            c.sender_mask)
      && am(c.target_mode, f.target_proto_addr, c.target_addr,
            c.target_mask)
      && q3(c.sha_mode, f.kind == op_arp,
            f.sender_hw_addr == f.frame_source_mac)
      && q3(c.tha_mode, f.kind == op_rarp,
            f.target_hw_addr == f.frame_source_mac)
      && q3(c.len_mode, 1'b1, f.hw_len == 8'h06 && f.proto_len == 8'h04)
      && q3(c.hrd_mode, 1'b1, f.hw_type == 16'h0001)
      && q3(c.pro_mode, 1'b1, f.proto_type == 16'h0800);
  endfunction
  // queue keeps order; one result per frame with no back-pressure
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
    if (result_valid === 1'b1) begin
      e = (q.size() == 0) ? 1'b0 : q.pop_front();
      hits <= hits + e;
      check(entry_hit, e);
    end
  end
  initial begin
    seed = $urandom(32'hb7dbe65a);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(off_ctrl, 32'h0000_3fff, axi_okay);
    rd(off_sender_mask, 32'hffff_ffff, axi_okay);
    rd(off_target_addr, 32'h0, axi_okay);
    rd(8'h1c, 32'h0, axi_slverr);
    wr(8'h1c, 32'h1, axi_slverr);
    wr(off_ctrl, 32'hffff_ffff, axi_okay);
    rd(off_ctrl, 32'h0000_7fff, axi_okay);
    for (k = 0; k < 40; k++) begin
      c = entry_cfg_s'({$urandom, $urandom, $urandom, $urandom, $urandom});
      en = ($urandom_range(0, 7) != 0);
      wr(off_ctrl, {17'h0, en, c.pro_mode, c.hrd_mode, c.len_mode,
         c.tha_mode, c.sha_mode, c.target_mode, c.sender_mode}, axi_okay);
      wr(off_sender_addr, c.sender_addr, axi_okay);
      wr(off_sender_mask, c.sender_mask, axi_okay);
      wr(off_target_addr, c.target_addr, axi_okay);
      wr(off_target_mask, c.target_mask, axi_okay);
      for (j = 0; j < 20; j++) begin
        f = frame;
        f.kind = arp_kind_e'($urandom_range(0, 2));
        f.sender_proto_addr = near(c.sender_addr, c.sender_mask, $urandom);
        f.target_proto_addr = near(c.target_addr, c.target_mask, $urandom);
        if ($urandom_range(0, 1)) f.sender_hw_addr = f.frame_source_mac;
        if ($urandom_range(0, 1)) f.target_hw_addr = f.frame_source_mac;
        if ($urandom_range(0, 1)) {f.hw_len, f.proto_len} = 16'h0604;
        if ($urandom_range(0, 1)) f.hw_type = hw_type_ethernet;
        if ($urandom_range(0, 1)) f.proto_type = proto_type_ip;
        last = ref_hit(f);
        q.push_back(last);
        parser_model_inst.send(f);
        if ($urandom_range(0, 1)) parser_model_inst.idle();
      end
      parser_model_inst.idle();
      rd(off_status, {31'h0, last}, axi_okay);
    end
    repeat (3) @(posedge aclk);
    check(q.size(), 0);
    rd(off_hit_count, hits, axi_okay);
    wr(off_hit_count, 32'h0, axi_okay);
    rd(off_hit_count, 32'h0, axi_okay);
    close_out();
  end
endmodule
